// ===== verilog/bilps_pkg.sv
/*
 package for the boot image loader and start-up PLL select block:
 offsets, field positions, reset values, timing and the loader states.
 assumes a single 40 MHz clock domain.
*/
package bilps_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int BOOT_DELAY_NS = 15000;
    // least time, so round up
    localparam int BOOT_DELAY_CYC = (BOOT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_W = 10;
    localparam int SEC_BOOT_BIT = 5;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_SKIP = 32'h0D15AB1E;
    localparam logic [31:0] BOOT_START_ADDR = 32'h00000000;
    // register byte offsets
    localparam logic [3:0] REG_PLL_CFG = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CRC = 4'h8;
    localparam logic [3:0] REG_LEN = 4'hC;
    // pll config field positions
    localparam int PLL_F_LSB = 0;
    localparam int PLL_R_LSB = 16;
    localparam int PLL_DIV_LSB = 24;
    // strap table values
    localparam logic [11:0] F_STRAP_00 = 12'h09F;
    localparam logic [11:0] F_STRAP_11 = 12'h03F;
    localparam logic [11:0] F_STRAP_10 = 12'h01F;
    localparam logic [11:0] F_STRAP_01 = 12'h00F;
    localparam logic [2:0] DIV_STRAP = 3'h1;
    localparam logic [5:0] R_STRAP = 6'h00;

    typedef enum logic [2:0] {
        S_RESET = 3'h0,
        S_WAIT = 3'h1,
        S_SEL = 3'h2,
        S_LEN = 3'h3,
        S_PROG = 3'h4,
        S_CHK = 3'h5,
        S_RUN = 3'h6,
        S_HALT = 3'h7
    } bilps_state_e;

    // feedback multiplier picked by {strap1, strap0}
    function automatic logic [11:0] bilps_strap_f(input logic [1:0] s);
        logic [11:0] f;
        f = F_STRAP_00;
        unique case (s)
            2'h0: f = F_STRAP_00;
            2'h3: f = F_STRAP_11;
            2'h2: f = F_STRAP_10;
            2'h1: f = F_STRAP_01;
        endcase
        return f;
    endfunction
endpackage

// ===== verilog/bilps_sync2.sv
/*
 two flip-flop synchroniser for pin levels.
 assumes the inputs change slowly relative to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module bilps_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// ===== verilog/bilps_crc_byte.sv
/*
 one-byte step of the reflected CRC-32.
 purely combinational; the caller holds the running value.
*/
`timescale 1ns/1ps
`default_nettype none
module bilps_crc_byte #(
    parameter logic [31:0] POLY = 32'hEDB88320
) (
    input wire logic [31:0] crc_in,
    input wire logic [7:0] data,
    output logic [31:0] crc_out
);
    // bits enter lsb first, matching the reflected form
    always_comb
    begin
        crc_out = crc_in ^ {24'h000000, data};
        for (int i = 0; i < 8; i++)
        begin
            crc_out = crc_out[0] ? ((crc_out >> 1) ^ POLY) : (crc_out >> 1);
        end
    end
endmodule
`default_nettype wire

// ===== verilog/bilps_loader.sv
/*
 start-up logic: reset hold, strap-based PLL preset, boot image load
 from flash or OTP into RAM with CRC check, and an Avalon-MM slave
 for PLL configuration and status.
 assumes flash, OTP and RAM ports run on clk; pins are asynchronous.
*/
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bilps_loader #(
    parameter int RAM_AW = 16, parameter int FLASH_AW = 24, parameter int OTP_AW = 11
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic rst_n_pin,
    input wire logic pll_ratio_strap0,
    input wire logic pll_ratio_strap1,
    input wire logic [31:0] security_reg,
    output logic gpio_pulldown_en,
    output logic flash_rd,
    output logic [FLASH_AW-1:0] flash_addr,
    input wire logic flash_valid,
    input wire logic [7:0] flash_data,
    output logic otp_rd,
    output logic [OTP_AW-1:0] otp_addr,
    input wire logic otp_valid,
    input wire logic [31:0] otp_rdata,
    output logic ram_we,
    output logic [RAM_AW-1:0] ram_addr,
    output logic [31:0] ram_wdata,
    output logic core_run,
    output logic [31:0] core_pc,
    output logic boot_fail,
    output logic [2:0] pll_output_divider,
    output logic [11:0] pll_f,
    output logic [5:0] pll_r,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    localparam logic [bilps_pkg::WAIT_W-1:0] WAIT_LAST =
        bilps_pkg::WAIT_W'(bilps_pkg::BOOT_DELAY_CYC - 1);

    bilps_pkg::bilps_state_e state;
    logic rst_n_q, boot_rst, sec_boot_q, fetch_pend, fetching;
    logic rx_valid, last_lane, chk_ok, bus_wr;
    logic [1:0] strap_q, lane;
    logic [bilps_pkg::WAIT_W-1:0] wait_cnt;
    logic [31:0] fetch_addr, crc_q, crc_next, len_word, asm_word, chk_word;
    logic [31:0] len_nx, asm_nx, chk_nx, words_left;
    logic [7:0] rx_byte;
    logic [RAM_AW-1:0] wr_addr;
    logic [3:0] reg_sel;

    // pins cross into clk before anything reads them
    bilps_sync2 #(.W(3)) u_sync (
        .clk(clk),
        .srst(srst),
        .d({rst_n_pin, pll_ratio_strap1, pll_ratio_strap0}),
        .q({rst_n_q, strap_q})
    );
    bilps_crc_byte #(.POLY(bilps_pkg::CRC_POLY)) u_crc (
        .crc_in(crc_q),
        .data(rx_byte),
        .crc_out(crc_next)
    );

    assign boot_rst = srst | ~rst_n_q;
    // byte stream view of the selected source
    assign lane = fetch_addr[1:0];
    assign last_lane = (lane == 2'h3);
    assign fetching = (state == bilps_pkg::S_LEN) || (state == bilps_pkg::S_PROG) ||
                      (state == bilps_pkg::S_CHK);
    assign rx_valid = fetch_pend & (sec_boot_q ? otp_valid : flash_valid);
    assign rx_byte = sec_boot_q ? otp_rdata[8*lane +: 8] : flash_data;
    assign len_nx = {rx_byte, len_word[31:8]};
    assign asm_nx = {rx_byte, asm_word[31:8]};
    assign chk_nx = {rx_byte, chk_word[31:8]};
    assign chk_ok = (chk_nx == bilps_pkg::CRC_SKIP) || (chk_nx == ~crc_q);
    assign reg_sel = {avs_address[3:2], 2'h0};
    assign bus_wr = avs_write & ~avs_waitrequest;
    // loader sequence
    always_ff @(posedge clk)
    begin
        if (boot_rst)
        begin
            state <= bilps_pkg::S_RESET;
        end
        else
        begin
            unique case (state)
                bilps_pkg::S_RESET: state <= bilps_pkg::S_WAIT;
                bilps_pkg::S_WAIT:
                    if (wait_cnt == WAIT_LAST)
                        state <= bilps_pkg::S_SEL;
                bilps_pkg::S_SEL: state <= bilps_pkg::S_LEN;
                // empty program goes straight to check word
                bilps_pkg::S_LEN:
                    if (rx_valid && last_lane)
                        state <= (len_nx == 32'h00000000) ? bilps_pkg::S_CHK : bilps_pkg::S_PROG;
                bilps_pkg::S_PROG:
                    if (rx_valid && last_lane && words_left == 32'h00000001)
                        state <= bilps_pkg::S_CHK;
                bilps_pkg::S_CHK:
                    if (rx_valid && last_lane)
                        state <= chk_ok ? bilps_pkg::S_RUN : bilps_pkg::S_HALT;
                bilps_pkg::S_RUN, bilps_pkg::S_HALT: state <= state;
            endcase
        end
    end
    // delay counter; least time taken, within the allowed window
    always_ff @(posedge clk)
    begin
        if (boot_rst || state != bilps_pkg::S_WAIT)
            wait_cnt <= '0;
        else
            wait_cnt <= wait_cnt + 1'b1;
    end
    always_ff @(posedge clk)
    begin
        gpio_pulldown_en <= boot_rst;
    end
    // boot source latched once, so a later change cannot mix sources
    always_ff @(posedge clk)
    begin
        if (boot_rst)
            sec_boot_q <= 1'b0;
        else if (state == bilps_pkg::S_SEL)
            sec_boot_q <= security_reg[bilps_pkg::SEC_BOOT_BIT];
    end
    // byte fetch; OTP word reread per byte, trading speed for one path
    always_ff @(posedge clk)
    begin
        if (boot_rst)
        begin
            fetch_pend <= 1'b0;
            fetch_addr <= bilps_pkg::BOOT_START_ADDR;
            flash_rd <= 1'b0;
            otp_rd <= 1'b0;
            flash_addr <= '0;
            otp_addr <= '0;
        end
        else
        begin
            flash_rd <= 1'b0;
            otp_rd <= 1'b0;
            if (fetching && !fetch_pend)
            begin
                fetch_pend <= 1'b1;
                flash_rd <= ~sec_boot_q;
                otp_rd <= sec_boot_q;
                flash_addr <= fetch_addr[FLASH_AW-1:0];
                otp_addr <= fetch_addr[OTP_AW+1:2];
            end
            else if (rx_valid)
            begin
                fetch_pend <= 1'b0;
                fetch_addr <= fetch_addr + 32'h00000001;
            end
        end
    end

    // word assembly and CRC
    always_ff @(posedge clk)
    begin
        if (boot_rst)
        begin
            crc_q <= bilps_pkg::CRC_INIT;
            len_word <= '0;
            asm_word <= '0;
            chk_word <= '0;
            words_left <= '0;
        end
        else if (rx_valid)
        begin
            if (state == bilps_pkg::S_LEN)
            begin
                len_word <= len_nx;
                crc_q <= crc_next;
                if (last_lane)
                    words_left <= len_nx;
            end
            else if (state == bilps_pkg::S_PROG)
            begin
                asm_word <= asm_nx;
                crc_q <= crc_next;
                if (last_lane)
                    words_left <= words_left - 32'h00000001;
            end
            else if (state == bilps_pkg::S_CHK)
            begin
                chk_word <= chk_nx;
            end
        end
    end
    // words land from the lowest RAM address up
    always_ff @(posedge clk)
    begin
        if (boot_rst)
        begin
            ram_we <= 1'b0;
            ram_addr <= '0;
            ram_wdata <= '0;
            wr_addr <= bilps_pkg::BOOT_START_ADDR[RAM_AW-1:0];
        end
        else
        begin
            ram_we <= 1'b0;
            if (state == bilps_pkg::S_PROG && rx_valid && last_lane)
            begin
                ram_we <= 1'b1;
                ram_addr <= wr_addr;
                ram_wdata <= asm_nx;
                wr_addr <= wr_addr + 1'b1;
            end
        end
    end
    // start or halt once the check word is in
    always_ff @(posedge clk)
    begin
        if (boot_rst)
        begin
            core_run <= 1'b0;
            boot_fail <= 1'b0;
            core_pc <= bilps_pkg::BOOT_START_ADDR;
        end
        else if (state == bilps_pkg::S_CHK && rx_valid && last_lane)
        begin
            // run only on a good check
            core_run <= chk_ok;
            boot_fail <= ~chk_ok;
            core_pc <= bilps_pkg::BOOT_START_ADDR;
        end
    end

    // pll setting; one value drives switch, tile and reference clocks
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pll_f <= bilps_pkg::F_STRAP_00;
            pll_r <= bilps_pkg::R_STRAP;
            pll_output_divider <= bilps_pkg::DIV_STRAP;
        end
        else if (state == bilps_pkg::S_RESET)
        begin
            pll_f <= bilps_pkg::bilps_strap_f(strap_q);
            pll_r <= bilps_pkg::R_STRAP;
            pll_output_divider <= bilps_pkg::DIV_STRAP;
        end
        else if (bus_wr && reg_sel == bilps_pkg::REG_PLL_CFG)
        begin
            pll_f <= avs_writedata[bilps_pkg::PLL_F_LSB +: 12];
            pll_r <= avs_writedata[bilps_pkg::PLL_R_LSB +: 6];
            pll_output_divider <= avs_writedata[bilps_pkg::PLL_DIV_LSB +: 3];
        end
    end

    // avalon slave: one wait cycle, read data sampled with the answer
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= '0;
        end
        else if ((avs_read || avs_write) && avs_waitrequest)
        begin
            avs_waitrequest <= 1'b0;
            unique case (reg_sel)
                bilps_pkg::REG_PLL_CFG:
                    avs_readdata <= {5'h00, pll_output_divider, 2'h0, pll_r, 4'h0, pll_f};
                bilps_pkg::REG_STATUS:
                    avs_readdata <= {24'h000000, strap_q, boot_fail, core_run, sec_boot_q, state};
                bilps_pkg::REG_CRC: avs_readdata <= crc_q;
                bilps_pkg::REG_LEN: avs_readdata <= len_word;
            endcase
        end
        else
        begin
            avs_waitrequest <= 1'b1;
        end
    end

    // checks
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);

    property p_hold_reset;
        !rst_n_q |=> state == bilps_pkg::S_RESET;
    endproperty
    a_hold_reset: assert property (p_hold_reset) else $error("reset pin low but loader moving");
    property p_pulldown;
        state == bilps_pkg::S_RESET |-> gpio_pulldown_en;
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("pull-down off during reset");
    property p_boot_delay;
        state == bilps_pkg::S_SEL |-> $past(state) == bilps_pkg::S_WAIT && $past(wait_cnt) == WAIT_LAST;
    endproperty
    a_boot_delay: assert property (p_boot_delay) else $error("boot started before delay");
    property p_src_sel;
        (flash_rd |-> !sec_boot_q) and (otp_rd |-> sec_boot_q);
    endproperty
    a_src_sel: assert property (p_src_sel) else $error("read from wrong boot source");
    property p_first_addr;
        state == bilps_pkg::S_SEL |-> ##2 ((flash_rd && flash_addr == '0) || (otp_rd && otp_addr == '0));
    endproperty
    a_first_addr: assert property (p_first_addr) else $error("first fetch not at address 0");
    property p_len_words;
        $rose(core_run) |-> wr_addr == len_word[RAM_AW-1:0];
    endproperty
    a_len_words: assert property (p_len_words) else $error("word count differs from length");
    property p_run_check;
        $rose(core_run) |-> chk_word == bilps_pkg::CRC_SKIP || chk_word == ~crc_q;
    endproperty
    a_run_check: assert property (p_run_check) else $error("started without a valid check");
    property p_run_pc;
        core_run |-> core_pc == bilps_pkg::BOOT_START_ADDR && state == bilps_pkg::S_RUN;
    endproperty
    a_run_pc: assert property (p_run_pc) else $error("run not from lowest address");
    property p_halt;
        state == bilps_pkg::S_HALT |-> boot_fail && !core_run ##1 !core_run;
    endproperty
    a_halt: assert property (p_halt) else $error("halted loader let core run");
    property p_strap;
        state == bilps_pkg::S_WAIT && $past(state) == bilps_pkg::S_RESET
            |-> pll_f == bilps_pkg::bilps_strap_f($past(strap_q)) && pll_r == bilps_pkg::R_STRAP;
    endproperty
    a_strap: assert property (p_strap) else $error("pll preset not from straps");
    property p_pll_write;
        bus_wr && reg_sel == bilps_pkg::REG_PLL_CFG && state != bilps_pkg::S_RESET
            |=> pll_f == $past(avs_writedata[11:0]) && pll_output_divider == $past(avs_writedata[26:24]);
    endproperty
    a_pll_write: assert property (p_pll_write) else $error("pll write not applied");
    property p_bus_answer;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    c_run_skip: cover property ($rose(core_run) && chk_word == bilps_pkg::CRC_SKIP);
    c_run_crc: cover property ($rose(core_run) && chk_word != bilps_pkg::CRC_SKIP);
    c_halt: cover property ($rose(boot_fail));
    c_otp_boot: cover property (otp_rd && sec_boot_q);
endmodule
`default_nettype wire

// ===== testbench/bilps_src_model.sv
/*
 flash and otp source model facing the loader's fetch ports.
 assumes the bench fills mem before the loader starts fetching.
*/
`timescale 1ns/1ps
`default_nettype none
module bilps_src_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic slow,
    input wire logic flash_rd,
    input wire logic [23:0] flash_addr,
    output logic flash_valid,
    output logic [7:0] flash_data,
    input wire logic otp_rd,
    input wire logic [10:0] otp_addr,
    output logic otp_valid,
    output logic [31:0] otp_rdata
);
    logic [7:0] mem [0:63];
    logic pend;
    logic is_otp;
    int a;
    int cnt;
    // known start so the idle toggling below is defined
    initial
    begin
        flash_valid = 1'b0;
        otp_valid = 1'b0;
        flash_data = 8'h00;
        otp_rdata = 32'h00000000;
        pend = 1'b0;
    end
    // one request at a time; idle lines toggle so a stale byte never matches
    always @(posedge clk)
    begin
        flash_valid <= 1'b0;
        otp_valid <= 1'b0;
        flash_data <= ~flash_data;
        otp_rdata <= ~otp_rdata;
        if (srst)
            pend <= 1'b0;
        else if (flash_rd || otp_rd)
        begin
            pend <= 1'b1;
            is_otp <= otp_rd;
            a <= otp_rd ? int'(otp_addr) * 4 : int'(flash_addr);
            cnt <= slow ? 3 : 0;
        end
        else if (pend && cnt > 0)
            cnt <= cnt - 1;
        else if (pend)
        begin
            pend <= 1'b0;
            flash_valid <= !is_otp;
            otp_valid <= is_otp;
            if (is_otp)
                otp_rdata <= {mem[a + 3], mem[a + 2], mem[a + 1], mem[a]};
            else
                flash_data <= mem[a];
        end
    end
endmodule
`default_nettype wire

// ===== testbench/boot_image_loader_pll_select_tb.sv
/*
 self-checking bench for the loader: four boots, then register access.
 assumes the source model answers every fetch; one 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module boot_image_loader_pll_select_tb;
    logic clk, srst, rst_n_pin, pll_ratio_strap0, pll_ratio_strap1, slow;
    logic [31:0] security_reg, avs_writedata, avs_readdata, otp_rdata, ram_wdata, core_pc, rd;
    logic [3:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest, gpio_pulldown_en, flash_rd, flash_valid;
    logic otp_rd, otp_valid, ram_we, core_run, boot_fail;
    logic [23:0] flash_addr;
    logic [7:0] flash_data;
    logic [10:0] otp_addr;
    logic [15:0] ram_addr;
    logic [2:0] pll_output_divider;
    logic [11:0] pll_f;
    logic [5:0] pll_r;
    logic [47:0] exp_q [$];
    int errors, comparisons, cyc;

    bilps_loader uut (.clk, .srst, .rst_n_pin, .pll_ratio_strap0, .pll_ratio_strap1,
        .security_reg, .gpio_pulldown_en, .flash_rd, .flash_addr, .flash_valid, .flash_data,
        .otp_rd, .otp_addr, .otp_valid, .otp_rdata, .ram_we, .ram_addr, .ram_wdata, .core_run,
        .core_pc, .boot_fail, .pll_output_divider, .pll_f, .pll_r, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
    bilps_src_model fm (.clk, .srst, .slow, .flash_rd, .flash_addr, .flash_valid, .flash_data,
        .otp_rd, .otp_addr, .otp_valid, .otp_rdata);

    // 25 ns period
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // reflected crc step, lsb of each byte first
    function automatic logic [31:0] crc_next(input logic [31:0] c, input logic [7:0] b);
        c = c ^ {24'h000000, b};
        for (int i = 0; i < 8; i++)
            c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
        return c;
    endfunction

    // one bus cycle, held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
        output logic [31:0] rdat);
        @(posedge clk);
        avs_address <= adr;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // kind 0 good crc, 1 skip marker with empty program, 2 wrong crc
    task automatic boot(input logic [1:0] s, input logic otp, input int kind);
        logic [31:0] n, crc, w, cw;
        logic [11:0] f;
        int cnt;
        n = kind == 1 ? 0 : $urandom_range(4, 1);
        srst <= 1'b1;
        rst_n_pin <= 1'b0;
        // straps steady from before reset onward
        {pll_ratio_strap1, pll_ratio_strap0} <= s;
        security_reg <= ($urandom() & ~32'h20) | {26'h0, otp, 5'h0};
        slow <= otp ^ s[0];
        crc = 32'hFFFFFFFF;
        for (int i = 0; i < 4; i++)
        begin
            fm.mem[i] = n[8 * i +: 8];
            crc = crc_next(crc, n[8 * i +: 8]);
        end
        for (int j = 0; j < n; j++)
        begin
            w = $urandom();
            for (int i = 0; i < 4; i++)
            begin
                fm.mem[4 + 4 * j + i] = w[8 * i +: 8];
                crc = crc_next(crc, w[8 * i +: 8]);
            end
            exp_q.push_back({16'(j), w});
        end
        cw = kind == 1 ? 32'h0D15AB1E : (kind == 2 ? crc : ~crc);
        for (int i = 0; i < 4; i++)
            fm.mem[4 + 4 * n + i] = cw[8 * i +: 8];
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (20) @(posedge clk);
        // pin low: pulldowns on, nothing fetched or started
        chk({gpio_pulldown_en, flash_rd, otp_rd, core_run}, 4'b1000);
        // board releases reset only once supplies settled
        rst_n_pin <= 1'b1;
        cnt = 0;
        do
        begin
            @(posedge clk);
            cnt++;
        end while (!(flash_rd || otp_rd));
        chk(cnt >= 600 && cnt <= 6000, 1);
        chk({otp_rd, flash_rd}, {otp, !otp});
        chk(otp ? otp_addr : flash_addr, 0);
        f = s == 2'h0 ? 12'h09F : (s == 2'h3 ? 12'h03F : (s == 2'h2 ? 12'h01F : 12'h00F));
        chk({pll_output_divider, pll_r, pll_f}, {3'h1, 6'h00, f});
        while (!(core_run || boot_fail))
            @(posedge clk);
        repeat (20) @(posedge clk);
        chk({core_run, boot_fail}, {kind != 2, kind == 2});
        chk(core_pc, 0);
        chk(exp_q.size(), 0);
        exp_q.delete();
    endtask

    // every ram write takes the oldest expected word
    always @(posedge clk)
    begin
        if (ram_we === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(1, 0);
            else
                chk({ram_addr, ram_wdata}, exp_q.pop_front());
        end
    end

    // hang guard, far above four boots
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            test_done();
        end
    end

    initial
    begin
        srst = 1'b1;
        rst_n_pin = 1'b0;
        {pll_ratio_strap1, pll_ratio_strap0} = 2'h0;
        slow = 1'b0;
        security_reg = 32'h00000000;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        void'($urandom(46));
        boot(2'h0, 1'b0, 0);
        boot(2'h3, 1'b0, 1);
        boot(2'h2, 1'b0, 2);
        boot(2'h1, 1'b1, 0);
        av(1'b1, 4'h0, 32'h03050123, rd);
        repeat (2) @(posedge clk);
        chk({pll_output_divider, pll_r, pll_f}, {3'h3, 6'h05, 12'h123});
        av(1'b0, 4'h0, 32'h00000000, rd);
        chk(rd, 32'h03050123);
        // status is read-only: run, otp boot, straps 01
        av(1'b1, 4'h4, 32'hFFFFFFFF, rd);
        av(1'b0, 4'h4, 32'h00000000, rd);
        chk(rd, 32'h0000005E);
        test_done();
    end
endmodule
`default_nettype wire
